// ---- balu_core.sv ----
// Byte ALU datapath: subtract, exclusive-OR and nibble swap with carry, digit carry, zero.
// Assumes the core supplies the file operand and performs file write-back.
//
// Contract
// - Register subtract: file minus working; dest 0 to working, 1 to file.
// - Register subtract updates carry, digit carry and zero only.
// - Digit carry is 0 when working low nibble exceeds operand's, else 1.
// - Literal XOR with working into working, zero flag only.
// - Nibble swap of file, dest select, no flag changes.
// - Register XOR with working, dest select, zero flag only.
// - Literal minus working into working, carry, digit carry and zero as subtract.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module balu_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Instruction request, one cycle per valid pulse
    input wire logic req_valid,
    input wire balu_pkg::balu_req_s req,
    // File register write-back
    output balu_pkg::balu_file_wb_s file_wb,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Live state
    output logic [7:0] working,
    output logic [2:0] status
);

    ////////////////////////////////////////////////////////////////////////////
    // Subtraction with inverted-borrow flags, shared by both subtract forms
    function automatic logic [9:0] balu_sub(input logic [7:0] minuend,
                                           input logic [7:0] subtrahend);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, minuend} - {1'b0, subtrahend};
        low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
        // Result, carry, digit carry; a borrow out clears the flag
        balu_sub = {full[7:0], ~full[8], ~low[4]};
    endfunction : balu_sub

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] last_result;
    logic [7:0] next_working;
    logic [2:0] next_status;
    logic [7:0] next_last_result;
    balu_pkg::balu_file_wb_s next_file_wb;
    logic [7:0] next_reg_rdata;
    logic [7:0] result;
    logic [9:0] sub_out;
    logic to_file;

    always_comb
    begin
        next_working = working;
        next_status = status;
        next_last_result = last_result;
        next_file_wb = '0;
        result = 8'h00;
        sub_out = 10'h000;
        to_file = 1'b0;
        // Software writes take effect first; an instruction in the same cycle overrides only the working value or flags it writes
        if (reg_wr && reg_addr == balu_pkg::BALU_REG_WORKING)
        begin
            next_working = reg_wdata;
        end
        if (reg_wr && reg_addr == balu_pkg::BALU_REG_STATUS)
        begin
            next_status = reg_wdata[2:0];
        end
        if (req_valid)
        begin
            case (req.op)
                balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE:
                begin
                    sub_out = balu_sub(req.file_value, working);
                    result = sub_out[9:2];
                    to_file = (req.dest == balu_pkg::BALU_DEST_FILE);
                    next_status[balu_pkg::BALU_STAT_CARRY] = sub_out[1];
                    next_status[balu_pkg::BALU_STAT_DIGIT_CARRY] = sub_out[0];
                    next_status[balu_pkg::BALU_STAT_ZERO] = (result == 8'h00);
                end
                balu_pkg::BALU_OP_SUB_WORKING_FROM_LITERAL:
                begin
                    sub_out = balu_sub(req.literal, working);
                    result = sub_out[9:2];
                    next_status[balu_pkg::BALU_STAT_CARRY] = sub_out[1];
                    next_status[balu_pkg::BALU_STAT_DIGIT_CARRY] = sub_out[0];
                    next_status[balu_pkg::BALU_STAT_ZERO] = (result == 8'h00);
                end
                balu_pkg::BALU_OP_XOR_LITERAL_WORKING:
                begin
                    result = working ^ req.literal;
                    next_status[balu_pkg::BALU_STAT_ZERO] = (result == 8'h00);
                end
                balu_pkg::BALU_OP_XOR_WORKING_FILE:
                begin
                    result = working ^ req.file_value;
                    to_file = (req.dest == balu_pkg::BALU_DEST_FILE);
                    next_status[balu_pkg::BALU_STAT_ZERO] = (result == 8'h00);
                end
                balu_pkg::BALU_OP_SWAP_FILE_NIBBLES:
                begin
                    result = {req.file_value[3:0], req.file_value[7:4]};
                    to_file = (req.dest == balu_pkg::BALU_DEST_FILE);
                end
                default:
                begin
                    result = last_result;
                end
            endcase
            if (req.op != balu_pkg::BALU_OP_NONE)
            begin
                next_last_result = result;
                if (to_file)
                begin
                    next_file_wb.wr = 1'b1;
                    next_file_wb.data = result;
                end
                else
                begin
                    next_working = result;
                end
            end
        end
    end

    always_comb
    begin
        next_reg_rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                balu_pkg::BALU_REG_WORKING: next_reg_rdata = working;
                balu_pkg::BALU_REG_STATUS: next_reg_rdata = {5'h00, status};
                balu_pkg::BALU_REG_LAST_RESULT: next_reg_rdata = last_result;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            working <= balu_pkg::BALU_WORKING_RST;
            status <= balu_pkg::BALU_STATUS_RST;
            last_result <= 8'h00;
            file_wb <= '0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            working <= next_working;
            status <= next_status;
            last_result <= next_last_result;
            file_wb <= next_file_wb;
            reg_rdata <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic op_ok;
    assign op_ok = req_valid && !reg_wr;

    property p_sub_file_value;
        @(posedge sys_clk) disable iff (!rstn)
        op_ok && req.op == balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE
        |=> ($past(req.dest) ? file_wb.data : working)
            == 8'($past(req.file_value) - $past(working));
    endproperty
    a_sub_file_value: assert property (p_sub_file_value) else $error("sub file result wrong");

    property p_sub_file_dest;
        @(posedge sys_clk) disable iff (!rstn)
        req_valid && req.op == balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE
        |=> file_wb.wr == $past(req.dest);
    endproperty
    a_sub_file_dest: assert property (p_sub_file_dest) else $error("sub dest wrong");

    property p_sub_carry;
        @(posedge sys_clk) disable iff (!rstn)
        req_valid && req.op == balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE
        |=> status[balu_pkg::BALU_STAT_CARRY] == ($past(working) <= $past(req.file_value));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("sub carry wrong");

    property p_sub_digit_carry;
        @(posedge sys_clk) disable iff (!rstn)
        req_valid && req.op == balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE
        |=> status[balu_pkg::BALU_STAT_DIGIT_CARRY]
            == ($past(working[3:0]) <= $past(req.file_value[3:0]));
    endproperty
    a_sub_digit_carry: assert property (p_sub_digit_carry) else $error("sub digit carry wrong");

    property p_xorl;
        @(posedge sys_clk) disable iff (!rstn)
        op_ok && req.op == balu_pkg::BALU_OP_XOR_LITERAL_WORKING
        |=> working == ($past(working) ^ $past(req.literal))
            && status[1:0] == $past(status[1:0]) && !file_wb.wr;
    endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong");

    property p_swap;
        @(posedge sys_clk) disable iff (!rstn)
        op_ok && req.op == balu_pkg::BALU_OP_SWAP_FILE_NIBBLES
        |=> status == $past(status) && last_result[7:4] == $past(req.file_value[3:0])
            && last_result[3:0] == $past(req.file_value[7:4]);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_xorf;
        @(posedge sys_clk) disable iff (!rstn)
        op_ok && req.op == balu_pkg::BALU_OP_XOR_WORKING_FILE
        |=> last_result == ($past(working) ^ $past(req.file_value))
            && file_wb.wr == $past(req.dest) && status[1:0] == $past(status[1:0]);
    endproperty
    a_xorf: assert property (p_xorf) else $error("file xor wrong");

    property p_subl;
        @(posedge sys_clk) disable iff (!rstn)
        op_ok && req.op == balu_pkg::BALU_OP_SUB_WORKING_FROM_LITERAL
        |=> working == 8'($past(req.literal) - $past(working))
            && status[balu_pkg::BALU_STAT_CARRY] == ($past(working) <= $past(req.literal));
    endproperty
    a_subl: assert property (p_subl) else $error("literal sub wrong");

    property p_zero;
        @(posedge sys_clk) disable iff (!rstn)
        op_ok && req.op != balu_pkg::BALU_OP_SWAP_FILE_NIBBLES
            && req.op != balu_pkg::BALU_OP_NONE
        |=> status[balu_pkg::BALU_STAT_ZERO] == (last_result == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule : balu_core

// ---- balu_pkg.sv ----
// Package for the byte ALU datapath: opcodes, status bit positions, register map.
// Assumes a single core clock; no other package is needed.
package balu_pkg;

    // Operation select
    typedef enum logic [2:0] {
        BALU_OP_NONE,
        BALU_OP_SUB_WORKING_FROM_FILE,
        BALU_OP_SUB_WORKING_FROM_LITERAL,
        BALU_OP_XOR_LITERAL_WORKING,
        BALU_OP_XOR_WORKING_FILE,
        BALU_OP_SWAP_FILE_NIBBLES
    } balu_op_e;

    // Destination select values
    localparam logic BALU_DEST_WORKING = 1'b0;
    localparam logic BALU_DEST_FILE = 1'b1;

    // Status register bit positions
    localparam int BALU_STAT_CARRY = 0;
    localparam int BALU_STAT_DIGIT_CARRY = 1;
    localparam int BALU_STAT_ZERO = 2;

    // Register map (word index on the plain register port)
    localparam logic [1:0] BALU_REG_WORKING = 2'h0;
    localparam logic [1:0] BALU_REG_STATUS = 2'h1;
    localparam logic [1:0] BALU_REG_LAST_RESULT = 2'h2;

    // Reset values
    localparam logic [7:0] BALU_WORKING_RST = 8'h00;
    localparam logic [2:0] BALU_STATUS_RST = 3'h0;

    // Instruction request bundle
    typedef struct packed {
        balu_op_e op;
        logic dest;
        logic [7:0] literal;
        logic [7:0] file_value;
    } balu_req_s;

    // File write-back bundle
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } balu_file_wb_s;

endpackage : balu_pkg

// ---- byte_alu_sub_xor_swap_tb_top.sv ----
// Self-checking bench for the byte ALU: operations, flags, write-back, register port.
// Assumes balu_pkg and balu_core are compiled first; bench drives all ports itself.
`timescale 1ns/1ps
module byte_alu_sub_xor_swap_tb_top;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    balu_pkg::balu_req_s req = '0;
    balu_pkg::balu_file_wb_s file_wb;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] working;
    logic [2:0] status;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] exp_w = 8'h00;
    logic [2:0] exp_st = 3'h0;
    logic [7:0] exp_last = 8'h00;

    balu_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
        .file_wb(file_wb), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .working(working), .status(status));

    always #5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({1'b0, reg_rdata}, {1'b0, exp});
    endtask : reg_read

    // Reference result and flags worked out here, then one request issued
    task automatic run_op(input balu_pkg::balu_op_e op, input logic dest,
                          input logic [7:0] lit, input logic [7:0] fv);
        logic [7:0] a;
        logic [7:0] r;
        logic [8:0] wb;
        a = (op == balu_pkg::BALU_OP_SUB_WORKING_FROM_LITERAL ||
             op == balu_pkg::BALU_OP_XOR_LITERAL_WORKING) ? lit : fv;
        r = exp_w;
        wb = 9'h000;
        case (op)
            balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE, balu_pkg::BALU_OP_SUB_WORKING_FROM_LITERAL:
            begin
                r = a - exp_w;
                exp_st[balu_pkg::BALU_STAT_CARRY] = (exp_w <= a);
                exp_st[balu_pkg::BALU_STAT_DIGIT_CARRY] = (exp_w[3:0] <= a[3:0]);
                exp_st[balu_pkg::BALU_STAT_ZERO] = (r == 8'h00);
            end
            balu_pkg::BALU_OP_XOR_LITERAL_WORKING, balu_pkg::BALU_OP_XOR_WORKING_FILE:
            begin
                r = exp_w ^ a;
                exp_st[balu_pkg::BALU_STAT_ZERO] = (r == 8'h00);
            end
            balu_pkg::BALU_OP_SWAP_FILE_NIBBLES:
                r = {fv[3:0], fv[7:4]};
            default:
                r = exp_w;
        endcase
        if (op != balu_pkg::BALU_OP_NONE)
        begin
            exp_last = r;
            if (dest == balu_pkg::BALU_DEST_FILE)
                wb = {1'b1, r};
            else
                exp_w = r;
        end
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{op: op, dest: dest, literal: lit, file_value: fv};
        @(posedge sys_clk);
        req_valid <= 1'b0;
        #1;
        chk({file_wb.wr, file_wb.data}, wb);
        chk({1'b0, working}, {1'b0, exp_w});
        chk({6'h00, status}, {6'h00, exp_st});
    endtask : run_op

    ////////////////////////////////////////////////////////////////////////////////
    // Ceiling well above the roughly 64 cycles the sequence needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_count++;
            complete_run();
        end
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        reg_read(balu_pkg::BALU_REG_STATUS, 8'h00);
        reg_read(balu_pkg::BALU_REG_WORKING, 8'h00);
        reg_write(balu_pkg::BALU_REG_WORKING, 8'h03);
        exp_w = 8'h03;
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE, 1'b1, 8'h00, 8'h05);
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE, 1'b0, 8'h00, 8'h05);
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE, 1'b0, 8'h00, 8'h01);
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE, 1'b0, 8'h00, 8'hff);
        reg_write(balu_pkg::BALU_REG_WORKING, 8'h1f);
        exp_w = 8'h1f;
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE, 1'b1, 8'h00, 8'h20);
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_LITERAL, 1'b0, 8'h30, 8'h00);
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_LITERAL, 1'b0, 8'h10, 8'h00);
        run_op(balu_pkg::BALU_OP_XOR_LITERAL_WORKING, 1'b0, 8'hff, 8'h00);
        run_op(balu_pkg::BALU_OP_XOR_LITERAL_WORKING, 1'b0, 8'h5a, 8'h00);
        run_op(balu_pkg::BALU_OP_XOR_WORKING_FILE, 1'b1, 8'h00, 8'h5a);
        run_op(balu_pkg::BALU_OP_XOR_WORKING_FILE, 1'b0, 8'h00, 8'h0f);
        run_op(balu_pkg::BALU_OP_SWAP_FILE_NIBBLES, 1'b0, 8'h00, 8'ha5);
        run_op(balu_pkg::BALU_OP_SWAP_FILE_NIBBLES, 1'b1, 8'h00, 8'h3c);
        // Last result is read-only; a write there must be ignored
        reg_write(balu_pkg::BALU_REG_LAST_RESULT, 8'hee);
        reg_read(balu_pkg::BALU_REG_LAST_RESULT, exp_last);
        run_op(balu_pkg::BALU_OP_NONE, 1'b1, 8'h00, 8'h77);
        // Flags set by hand must survive operations that leave them alone
        reg_write(balu_pkg::BALU_REG_STATUS, 8'h07);
        exp_st = 3'h7;
        run_op(balu_pkg::BALU_OP_SWAP_FILE_NIBBLES, 1'b0, 8'h00, 8'h12);
        run_op(balu_pkg::BALU_OP_XOR_LITERAL_WORKING, 1'b0, 8'h01, 8'h00);
        run_op(balu_pkg::BALU_OP_SUB_WORKING_FROM_FILE, 1'b0, 8'h00, 8'h21);
        reg_read(balu_pkg::BALU_REG_STATUS, {5'h00, exp_st});
        // Status write beside an instruction: the instruction owns only the zero flag
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= balu_pkg::BALU_REG_STATUS;
        reg_wdata <= 8'h03;
        req_valid <= 1'b1;
        req <= '{op: balu_pkg::BALU_OP_XOR_LITERAL_WORKING, dest: 1'b0, literal: exp_w,
                 file_value: 8'h00};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        req_valid <= 1'b0;
        #1;
        chk({1'b0, working}, 9'h000);
        chk({6'h00, status}, 9'h007);
        exp_w = 8'h00;
        exp_st = 3'h7;
        // Unmapped index: writes are dropped and reads return zero
        reg_write(2'h3, 8'h55);
        reg_read(2'h3, 8'h00);
        reg_read(balu_pkg::BALU_REG_WORKING, exp_w);
        complete_run();
    end
endmodule : byte_alu_sub_xor_swap_tb_top
